// [hdl/tmr_output_status_map.sv]
// Per-channel voted status map of a triplicated 40-channel output module
// Contract
// R1: Controller drives one command bit per channel
// R2: Voted state code 4 on, 2 off
// R3: Codes 5 short, 6 field, 7 channel
// R4: Code 3 open, 1 no supply, 0 unused
// R5: Voltage is median of three slices
// R6: Current is sum of three slices
// R7: Line fault on open, short, no supply
// R8: Line fault is majority of slice flags
// R9: Word one channels 1-16, lowest at LSB
// R10: Word two 17-32, word three 33-40
// R11: Disagreement bit set when slice codes differ
// R12: Chassis 1 controller, 2 to 15 expander
// R13: Slot 1-8 controller, 1-12 expander
// R14: Secondary position declared only when needed
// R15: Fatal slice forces housekeeping values to zero
// R16: Word three upper byte reads zero
`timescale 1ns/1ps
module tmr_output_status_map (
  input  wire logic        i_clk_sys,                // 200 MHz clock
  input  wire logic        i_resetn,                 // Async reset, low
  input  wire logic [39:0] i_command,                // Logical commands
  input  wire logic [39:0] i_slice_on_a,             // Slice A energized
  input  wire logic [39:0] i_slice_on_b,             // Slice B energized
  input  wire logic [39:0] i_slice_on_c,             // Slice C energized
  input  wire logic [119:0] i_code_a,                // Slice A raw codes
  input  wire logic [119:0] i_code_b,                // Slice B raw codes
  input  wire logic [119:0] i_code_c,                // Slice C raw codes
  input  wire logic [639:0] i_volt_a,                // Slice A voltages
  input  wire logic [639:0] i_volt_b,                // Slice B voltages
  input  wire logic [639:0] i_volt_c,                // Slice C voltages
  input  wire logic [639:0] i_curr_a,                // Slice A currents
  input  wire logic [639:0] i_curr_b,                // Slice B currents
  input  wire logic [639:0] i_curr_c,                // Slice C currents
  input  wire logic [911:0] i_housekeeping,          // Raw housekeeping
  input  wire logic        i_slice_fatal,            // Any slice fatal
  input  wire logic [3:0]  i_primary_chassis_number, // Chassis number
  input  wire logic [3:0]  i_primary_slot_number,    // Slot number
  input  wire logic        i_secondary_declared,     // Secondary given
  input  wire logic        i_secondary_start,        // May start secondary
  output logic [39:0]      o_drive,                  // Commands to slices
  output logic [119:0]     o_state_codes,            // Voted state codes
  output logic [639:0]     o_channel_voltage_values, // Median voltages
  output logic [719:0]     o_channel_current_values, // Summed currents
  output logic [39:0]      o_line_fault_flags,       // Voted line faults
  output logic [47:0]      o_slice_disagreement_words, // Three words
  output logic [911:0]     o_housekeeping_values,    // Gated housekeeping
  output logic             o_position_ok,            // Position valid
  output logic             o_position_bad            // Position invalid
);

  // ==========================================================
  // Per-channel combinational results
  // ==========================================================
  logic [119:0] next_codes;   // Voted codes
  logic [639:0] next_volt;    // Medians
  logic [719:0] next_curr;    // Sums
  logic [39:0]  next_flt;     // Voted faults
  logic [39:0]  next_dis;     // Disagreement per channel

  // Slice code classifier: line fault per slice
  function automatic logic is_line_fault(input logic [2:0] c);
    is_line_fault = (c == tmr_map_pkg::ST_OPEN) ||
                    (c == tmr_map_pkg::ST_SHORT) ||
                    (c == tmr_map_pkg::ST_NO_SUP);
  endfunction

  // Map a slice code; raw on/off is refined from the energized bit
  function automatic logic [2:0] slice_code(input logic [2:0] c,
                                            input logic on);
    if (c == tmr_map_pkg::ST_ON || c == tmr_map_pkg::ST_OFF) begin
      slice_code = on ? tmr_map_pkg::ST_ON : tmr_map_pkg::ST_OFF; // R2
    end else begin
      slice_code = c; // R3 R4
    end
  endfunction

  // Vote, median, sum and disagreement for every channel
  always_comb begin
    logic [2:0]  ca;
    logic [2:0]  cb;
    logic [2:0]  cc;
    logic signed [15:0] va;
    logic signed [15:0] vb;
    logic signed [15:0] vc;
    logic fa;
    logic fb;
    logic fc;
    ca = '0;
    cb = '0;
    cc = '0;
    va = '0;
    vb = '0;
    vc = '0;
    fa = 1'b0;
    fb = 1'b0;
    fc = 1'b0;
    next_codes = '0;
    next_volt  = '0;
    next_curr  = '0;
    next_flt   = '0;
    next_dis   = '0;
    for (int i = 0; i < tmr_map_pkg::CHANNELS; i++) begin
      ca = slice_code(i_code_a[i*3 +: 3], i_slice_on_a[i]);
      cb = slice_code(i_code_b[i*3 +: 3], i_slice_on_b[i]);
      cc = slice_code(i_code_c[i*3 +: 3], i_slice_on_c[i]);
      // Majority code; no two agree falls back to channel fault
      if (ca == cb || ca == cc) begin
        next_codes[i*3 +: 3] = ca; // R2
      end else if (cb == cc) begin
        next_codes[i*3 +: 3] = cb; // R2
      end else begin
        next_codes[i*3 +: 3] = tmr_map_pkg::ST_CHAN; // R3
      end
      next_dis[i] = (ca != cb) || (ca != cc); // R11
      fa = is_line_fault(ca); // R7
      fb = is_line_fault(cb);
      fc = is_line_fault(cc);
      next_flt[i] = (fa & fb) | (fa & fc) | (fb & fc); // R8
      va = i_volt_a[i*16 +: 16];
      vb = i_volt_b[i*16 +: 16];
      vc = i_volt_c[i*16 +: 16];
      // Median of three signed readings; equal readings count as median
      if ((va >= vb && va <= vc) || (va <= vb && va >= vc)) begin
        next_volt[i*16 +: 16] = va; // R5
      end else if ((vb >= va && vb <= vc) ||
                   (vb <= va && vb >= vc)) begin
        next_volt[i*16 +: 16] = vb; // R5
      end else begin
        next_volt[i*16 +: 16] = vc; // R5
      end
      next_curr[i*18 +: 18] = 18'($signed(i_curr_a[i*16 +: 16])) +
                              18'($signed(i_curr_b[i*16 +: 16])) +
                              18'($signed(i_curr_c[i*16 +: 16])); // R6
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  // Command pass-through to the slices
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drive <= '0;
    end else begin
      o_drive <= i_command; // R1
    end
  end

  // Voted state codes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_state_codes <= '0;
    end else begin
      o_state_codes <= next_codes;
    end
  end

  // Voltages and currents
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_channel_voltage_values <= '0;
      o_channel_current_values <= '0;
    end else begin
      o_channel_voltage_values <= next_volt;
      o_channel_current_values <= next_curr;
    end
  end

  // Line faults
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_line_fault_flags <= '0;
    end else begin
      o_line_fault_flags <= next_flt;
    end
  end

  // Packed disagreement words, lowest channel at bit zero
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_slice_disagreement_words <= '0;
    end else begin
      o_slice_disagreement_words[15:0] <=
        next_dis[tmr_map_pkg::W1_BASE +: tmr_map_pkg::WORD_W]; // R9
      o_slice_disagreement_words[31:16] <=
        next_dis[tmr_map_pkg::W2_BASE +: tmr_map_pkg::WORD_W]; // R10
      o_slice_disagreement_words[39:32] <=
        next_dis[tmr_map_pkg::W3_BASE +: tmr_map_pkg::W3_USED]; // R10
      o_slice_disagreement_words[47:40] <= 8'h00; // R16
    end
  end

  // Housekeeping, cleared while a slice is fatal
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_housekeeping_values <= '0;
    end else if (i_slice_fatal) begin
      o_housekeeping_values <= '0; // R15
    end else begin
      o_housekeeping_values <= i_housekeeping;
    end
  end

  // ==========================================================
  // Position check
  // ==========================================================
  tmr_map_pkg::pos_state_t next_pos; // Verdict this cycle

  // Chassis and slot range check; secondary needed if it may start
  always_comb begin
    logic ok;
    ok = 1'b0;
    if (i_primary_chassis_number == tmr_map_pkg::CH_CTRL) begin
      ok = (i_primary_slot_number >= tmr_map_pkg::SLOT_MIN) &&
           (i_primary_slot_number <= tmr_map_pkg::SLOT_CTRL); // R12 R13
    end else if (i_primary_chassis_number <= tmr_map_pkg::CH_EXP_MAX &&
                 i_primary_chassis_number > tmr_map_pkg::CH_CTRL) begin
      ok = (i_primary_slot_number >= tmr_map_pkg::SLOT_MIN) &&
           (i_primary_slot_number <= tmr_map_pkg::SLOT_EXP); // R12 R13
    end
    if (i_secondary_start && !i_secondary_declared) begin
      ok = 1'b0; // R14
    end
    next_pos = ok ? tmr_map_pkg::POS_OK : tmr_map_pkg::POS_BAD;
  end

  // Verdict flags
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_position_ok  <= 1'b0;
      o_position_bad <= 1'b0;
    end else begin
      o_position_ok  <= (next_pos == tmr_map_pkg::POS_OK);
      o_position_bad <= (next_pos == tmr_map_pkg::POS_BAD);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb_sys @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  AST_DRIVE: assert property ( // R1
    ##1 o_drive == $past(i_command))
    else $error("drive does not follow command");
  AST_ON_CODE: assert property ( // R2
    (i_slice_on_a[0] && i_slice_on_b[0] && i_slice_on_c[0] &&
     i_code_a[2:0] == tmr_map_pkg::ST_ON &&
     i_code_b[2:0] == tmr_map_pkg::ST_ON &&
     i_code_c[2:0] == tmr_map_pkg::ST_ON)
    |=> o_state_codes[2:0] == tmr_map_pkg::ST_ON)
    else $error("energized channel not coded 4");
  AST_SHORT_CODE: assert property ( // R3
    (i_code_a[2:0] == tmr_map_pkg::ST_SHORT &&
     i_code_b[2:0] == tmr_map_pkg::ST_SHORT)
    |=> o_state_codes[2:0] == tmr_map_pkg::ST_SHORT)
    else $error("short not voted");
  AST_OPEN_CODE: assert property ( // R4
    (i_code_b[2:0] == tmr_map_pkg::ST_OPEN &&
     i_code_c[2:0] == tmr_map_pkg::ST_OPEN)
    |=> o_state_codes[2:0] == tmr_map_pkg::ST_OPEN)
    else $error("open not voted");
  AST_MEDIAN: assert property ( // R5
    ($signed(i_volt_a[15:0]) <= $signed(i_volt_b[15:0]) &&
     $signed(i_volt_b[15:0]) <= $signed(i_volt_c[15:0]))
    |=> o_channel_voltage_values[15:0] == $past(i_volt_b[15:0]))
    else $error("median wrong");
  AST_LINE_FAULT_FLAGS: assert property ( // R8
    o_line_fault_flags[0] |->
      is_line_fault($past(next_codes[2:0])) || $past(next_dis[0]))
    else $error("line fault without voted cause");
  AST_DISC_ZERO: assert property ( // R16
    o_slice_disagreement_words[47:40] == 8'h00)
    else $error("unused disagreement bits set");
  AST_DISC_MAP: assert property ( // R10
    ##1 o_slice_disagreement_words[32] == $past(next_dis[32]))
    else $error("channel 33 not at word three bit zero");
  AST_FATAL: assert property ( // R15
    i_slice_fatal |=> o_housekeeping_values == '0)
    else $error("housekeeping not zero while fatal");
  AST_POS: assert property ( // R13
    (i_primary_chassis_number == tmr_map_pkg::CH_CTRL &&
     i_primary_slot_number == tmr_map_pkg::SLOT_EXP)
    |=> o_position_bad)
    else $error("slot 12 accepted in controller chassis");
  AST_MEDIAN_TIE: assert property ( // R5
    ($signed(i_volt_a[15:0]) == $signed(i_volt_b[15:0]))
    |=> o_channel_voltage_values[15:0] == $past(i_volt_a[15:0]))
    else $error("median wrong when two readings are equal");
  AST_ON_NO_FAULT: assert property ( // R7
    (i_code_a[2:0] == tmr_map_pkg::ST_ON &&
     i_code_b[2:0] == tmr_map_pkg::ST_ON &&
     i_code_c[2:0] == tmr_map_pkg::ST_ON)
    |=> !o_line_fault_flags[0])
    else $error("line fault flagged on healthy channel");

  COV_DISAGREE: cover property (o_slice_disagreement_words[0]);
  COV_FATAL:    cover property (i_slice_fatal ##1 !i_slice_fatal);
  COV_POS_OK:   cover property (o_position_ok);
  COV_FAULT:    cover property (o_line_fault_flags[39]);

endmodule

// [include/tmr_map_pkg.sv]
// Constants and types for the triplicated output status map
package tmr_map_pkg;
  localparam int CHANNELS   = 40;  // Output channels
  localparam int SLICES     = 3;   // Redundant slices
  localparam int CODE_W     = 3;   // Width of a channel state code
  localparam int VAL_W      = 16;  // Width of a voltage or current value
  localparam int SUM_W      = 18;  // Width of a three-way sum
  localparam int WORD_W     = 16;  // Width of a disagreement word
  localparam int W1_BASE    = 0;   // First channel index of word one
  localparam int W2_BASE    = 16;  // First channel index of word two
  localparam int W3_BASE    = 32;  // First channel index of word three
  localparam int W3_USED    = 8;   // Channels carried by word three
  localparam int HK_COUNT   = 57;  // Housekeeping values
  localparam int CHASSIS_W  = 4;   // Chassis number width
  localparam int SLOT_W     = 4;   // Slot number width
  // Channel state codes
  localparam logic [2:0] ST_UNUSED  = 3'h0;
  localparam logic [2:0] ST_NO_SUP  = 3'h1;
  localparam logic [2:0] ST_OFF     = 3'h2;
  localparam logic [2:0] ST_OPEN    = 3'h3;
  localparam logic [2:0] ST_ON      = 3'h4;
  localparam logic [2:0] ST_SHORT   = 3'h5;
  localparam logic [2:0] ST_FIELD   = 3'h6;
  localparam logic [2:0] ST_CHAN    = 3'h7;
  // Chassis and slot limits
  localparam logic [3:0] CH_CTRL    = 4'h1;
  localparam logic [3:0] CH_EXP_MAX = 4'hf;
  localparam logic [3:0] SLOT_MIN   = 4'h1;
  localparam logic [3:0] SLOT_CTRL  = 4'h8;
  localparam logic [3:0] SLOT_EXP   = 4'hc;
  localparam logic [15:0] ZERO16    = 16'h0000;
  // Position check verdict
  typedef enum logic [1:0] {
    POS_UNKNOWN = 2'b00,
    POS_OK      = 2'b01,
    POS_BAD     = 2'b10
  } pos_state_t;
endpackage

// [testbench/processor_model.sv]
// Model of the supervising processor that feeds commands and position
`timescale 1ns/1ps
module processor_model (
  input  wire logic [39:0] i_cmd_req,      // Commands the test asks for
  input  wire logic [3:0]  i_chassis_req,  // Chassis the test asks for
  input  wire logic [3:0]  i_slot_req,     // Slot the test asks for
  input  wire logic        i_sec_start_req, // Start on secondary allowed
  output logic [39:0]      o_command,      // One command bit per channel
  output logic [3:0]       o_chassis,      // Primary chassis number
  output logic [3:0]       o_slot,         // Primary slot number
  output logic             o_sec_declared, // Secondary position given
  output logic             o_sec_start     // Secondary may start active
);
  // ===================================================================
  // Command and position outputs
  // One bit per channel, 1 energizes and 0 de-energizes
  assign o_command = i_cmd_req;
  // Position passed as asked; bad values only when a test wants them
  assign o_chassis = i_chassis_req;
  assign o_slot    = i_slot_req;
  // Secondary is declared exactly when it may start as the active one
  assign o_sec_start    = i_sec_start_req;
  assign o_sec_declared = i_sec_start_req;
endmodule

// [testbench/tb.sv]
// Self-checking testbench for the triplicated output status map
`timescale 1ns/1ps
module tb;
  // ===================================================================
  // Signals
  logic         clk = 1'b0;      // 200 MHz clock
  logic         resetn;          // Active low reset
  logic [39:0]  cmd_req, on_a, on_b, on_c, command, drive, lf;
  logic [119:0] code_a, code_b, code_c, codes, exp_codes;
  logic [639:0] volt_a, volt_b, volt_c, curr_a, curr_b, curr_c, volt_o;
  logic [639:0] exp_v;           // Expected medians
  logic [719:0] curr_o, exp_c;   // Summed currents, seen and expected
  logic [911:0] hk, hk_o;        // Housekeeping in and out
  logic [47:0]  disc;            // Disagreement words
  logic [3:0]   ch_req, slot_req, chassis, slot;
  logic         fatal, sec_req, sec_decl, sec_start, pos_ok, pos_bad;
  logic [15:0]  va, vb, vc;      // Scratch per-channel values
  int           error_cnt = 0;   // Mismatches
  int           samples_checked = 0; // Comparisons
  // Chassis, slot, start-secondary, expected verdict
  logic [9:0]   pos_tbl [10] = '{{4'h1, 4'h1, 1'b0, 1'b1},
    {4'h1, 4'h8, 1'b0, 1'b1}, {4'h1, 4'h9, 1'b0, 1'b0},
    {4'h1, 4'hc, 1'b0, 1'b0},
    {4'h2, 4'hc, 1'b0, 1'b1}, {4'hf, 4'hc, 1'b0, 1'b1},
    {4'hf, 4'hd, 1'b0, 1'b0}, {4'h0, 4'h1, 1'b0, 1'b0},
    {4'h3, 4'h0, 1'b0, 1'b0}, {4'h1, 4'h4, 1'b1, 1'b1}};

  // Clock generation
  always #2.5 clk = ~clk;

  // ===================================================================
  // Instances
  processor_model proc (.i_cmd_req(cmd_req), .i_chassis_req(ch_req),
    .i_slot_req(slot_req), .i_sec_start_req(sec_req),
    .o_command(command), .o_chassis(chassis), .o_slot(slot),
    .o_sec_declared(sec_decl), .o_sec_start(sec_start));
  tmr_output_status_map uut (.i_clk_sys(clk), .i_resetn(resetn),
    .i_command(command), .i_slice_on_a(on_a), .i_slice_on_b(on_b),
    .i_slice_on_c(on_c), .i_code_a(code_a), .i_code_b(code_b),
    .i_code_c(code_c), .i_volt_a(volt_a), .i_volt_b(volt_b),
    .i_volt_c(volt_c), .i_curr_a(curr_a), .i_curr_b(curr_b),
    .i_curr_c(curr_c), .i_housekeeping(hk), .i_slice_fatal(fatal),
    .i_primary_chassis_number(chassis), .i_primary_slot_number(slot),
    .i_secondary_declared(sec_decl), .i_secondary_start(sec_start),
    .o_drive(drive), .o_state_codes(codes),
    .o_channel_voltage_values(volt_o),
    .o_channel_current_values(curr_o), .o_line_fault_flags(lf),
    .o_slice_disagreement_words(disc), .o_housekeeping_values(hk_o),
    .o_position_ok(pos_ok), .o_position_bad(pos_bad));

  // ===================================================================
  // Tasks
  // Compare one value and count it
  task automatic check(input logic [911:0] seen, input logic [911:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: output differs", $time);
    end
  endtask

  // Same code on every channel of each slice
  task automatic fill(input logic [2:0] a, b, c, input logic [39:0] on);
    code_a = {40{a}};
    code_b = {40{b}};
    code_c = {40{c}};
    {on_a, on_b, on_c} = {3{on}};
  endtask

  // Let one edge register the inputs, then look
  task automatic step;
    @(negedge clk);
  endtask

  // Median of three signed values
  function automatic logic [15:0] med(input logic signed [15:0] a, b, c);
    logic signed [15:0] lo, hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    return (c < lo) ? lo : ((c > hi) ? hi : c);
  endfunction

  // Counts, verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end

  // ===================================================================
  // Test sequence
  initial begin
    resetn = 1'b0;
    {cmd_req, ch_req, slot_req, sec_req, fatal} = '0;
    {volt_a, volt_b, volt_c, curr_a, curr_b, curr_c, hk} = '0;
    fill(3'h2, 3'h2, 3'h2, 40'h00_0000_0000);
    repeat (5) @(negedge clk);
    check(codes, '0);
    check(hk_o, '0);
    resetn = 1'b1;
    $display("test reset done");
    // State codes 1 to 7, all slices agreeing; raw 4 refined to off
    for (int k = 1; k < 8; k++) begin
      cmd_req = 40'h55_5555_5555 ^ {40{k[0]}};
      fill(3'(k == 2 ? 4 : k), 3'(k == 2 ? 4 : k), 3'(k == 2 ? 4 : k),
           {40{k == 4}});
      step();
      check(drive, cmd_req);
      check(codes, {40{3'(k)}});
      check(lf, {40{k == 1 || k == 3 || k == 5}});
      check(disc, '0);
    end
    $display("test codes done");
    // Single slices outvoted at the start of words one and two, no majority at the end of word three
    fill(3'h2, 3'h2, 3'h2, '0);
    {code_a[2:0], code_b[2:0]} = {tmr_map_pkg::ST_SHORT,
                                  tmr_map_pkg::ST_SHORT};
    code_c[50:48] = tmr_map_pkg::ST_SHORT;
    {code_a[119:117], code_b[119:117], code_c[119:117]} = 9'h0ef;
    exp_codes = {40{tmr_map_pkg::ST_OFF}};
    exp_codes[2:0] = tmr_map_pkg::ST_SHORT;
    exp_codes[119:117] = tmr_map_pkg::ST_CHAN;
    step();
    check(codes, exp_codes);
    check(lf, 40'h80_0000_0001);
    check(disc, 48'h0080_0001_0001);
    // All channels disagree; upper byte of word three stays clear
    fill(3'h4, 3'h2, 3'h5, '0);
    on_a = '1;
    step();
    check(codes, {40{tmr_map_pkg::ST_CHAN}});
    check(disc, 48'h00ff_ffff_ffff);
    $display("test voting done");
    // Analog values, with currents near full scale
    for (int i = 0; i < 40; i++) begin
      volt_a[16*i +: 16] = 16'(i * 100);
      volt_b[16*i +: 16] = 16'(-7 * i);
      volt_c[16*i +: 16] = 16'(13 * i - 200);
      {va, vb, vc} = {16'h7fff, 16'(16'h7fff - 3 * i), 16'(-i)};
      {curr_a[16*i +: 16], curr_b[16*i +: 16], curr_c[16*i +: 16]} =
        {va, vb, vc};
      exp_c[18*i +: 18] = {{2{va[15]}}, va} + {{2{vb[15]}}, vb} +
                          {{2{vc[15]}}, vc};
      exp_v[16*i +: 16] = med(volt_a[16*i +: 16], volt_b[16*i +: 16],
                              volt_c[16*i +: 16]);
    end
    step();
    check(volt_o, exp_v);
    check(curr_o, exp_c);
    $display("test analog done");
    // Housekeeping gated by the fatal condition
    hk = {57{16'ha5c3}};
    step();
    check(hk_o, hk);
    fatal = 1'b1;
    step();
    check(hk_o, '0);
    fatal = 1'b0;
    step();
    check(hk_o, hk);
    $display("test housekeeping done");
    // Position verdicts across the chassis and slot limits
    for (int p = 0; p < 10; p++) begin
      {ch_req, slot_req, sec_req} = pos_tbl[p][9:1];
      step();
      check(pos_ok, pos_tbl[p][0]);
      check(pos_bad, !pos_tbl[p][0]);
    end
    $display("test position done");
    stop_test();
  end
endmodule
